//--- test/tb_top.sv
// Self-checking testbench for the waveform sample playback block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ==========================================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dac_oe, dig_oe, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [wsp_pkg::SAMPLE_W-1:0] dac_data, dac_level;
  logic [wsp_pkg::DIG_W-1:0] dig_out, pin_level;
  int fail_count, check_count;
  logic [7:0] mem [4] = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
  wsp_playback u_wsp_playback (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dac_data(dac_data), .dac_oe(dac_oe), .dig_out(dig_out), .dig_oe(dig_oe));
  wsp_sink_model u_wsp_sink_model (.dac_data(dac_data), .dac_oe(dac_oe), .dig_out(dig_out),
    .dig_oe(dig_oe), .dac_level(dac_level), .pin_level(pin_level));
  // ==========================================================================
  // Helpers
  task finish_test;
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  // Outputs read at an edge still show the value launched at the edge before.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp, "read data");
    cmp(er, 1'b0, "slave error");
  endtask : rdc
  // ==========================================================================
  // Scenarios
  task t_reset;
    cmp({dac_oe, dig_oe}, 2'b00, "reset drive");
    rdc(wsp_pkg::OFS_COUNT, 32'h0000_0800);
    rdc(wsp_pkg::OFS_HOLD, 32'h0000_0000);
    rdc(wsp_pkg::OFS_CTRL, 32'h0000_0000);
  endtask : t_reset
  task t_clamp;
    wr(wsp_pkg::OFS_COUNT, 32'h0000_0000);
    rdc(wsp_pkg::OFS_COUNT, 32'h0000_0001);
    wr(wsp_pkg::OFS_COUNT, 32'h0000_0FFF);
    rdc(wsp_pkg::OFS_COUNT, 32'h0000_0800);
  endtask : t_clamp
  task t_load;
    wr(wsp_pkg::OFS_WADDR, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(wsp_pkg::OFS_WDATA, {24'h0, mem[i]});
    end
    repeat (3) @(posedge pclk);
    cmp({dac_oe, dig_oe}, 2'b00, "load drive");
    rdc(wsp_pkg::OFS_WADDR, 32'h0000_0004);
  endtask : t_load
  // Entries past the count hold other values, so reading beyond it shows up as a mismatch.
  // The first sample shows two cycles after the restart edge.
  task watch(input logic bm, input int cnt, input int hold, input int n);
    int idx;
    repeat (2) @(posedge pclk);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      idx = (k / (hold > 0 ? hold : 1)) % cnt;
      if (bm) cmp({dig_oe, dac_oe, pin_level}, {2'b10, mem[idx][3:0]}, "pins");
      else cmp({dac_oe, dig_oe, dac_level}, {2'b10, mem[idx]}, "converter");
    end
  endtask : watch
  task play(input logic bm, input int cnt, input int hold, input int n);
    wr(wsp_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    cmp({dac_oe, dig_oe}, 2'b00, "disable drive");
    wr(wsp_pkg::OFS_COUNT, cnt);
    wr(wsp_pkg::OFS_HOLD, hold);
    wr(wsp_pkg::OFS_CTRL, {30'h0, bm, 1'b1});
    watch(bm, cnt, hold, n);
  endtask : play
  // Reloading data while running restarts at the first sample with a fresh hold.
  task t_reload;
    wr(wsp_pkg::OFS_WADDR, 32'h0000_0000);
    wr(wsp_pkg::OFS_WDATA, {24'h0, mem[0]});
    watch(1'b1, 4, 2, 6);
    wr(wsp_pkg::OFS_COUNT, 32'h0000_0001);
    rdc(wsp_pkg::OFS_STATUS, 32'h0000_0001);
  endtask : t_reload
  task t_midreset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp({dac_oe, dig_oe}, 2'b00, "mid-run reset drive");
    presetn <= 1'b1;
    rdc(wsp_pkg::OFS_COUNT, 32'h0000_0800);
    rdc(wsp_pkg::OFS_CTRL, 32'h0000_0000);
  endtask : t_midreset
  task t_unmapped;
    wr(8'h40, 32'hFFFF_FFFF);
    cmp(er, 1'b1, "unmapped write");
    apb(1'b0, 8'h40, 32'h0);
    cmp({er, rd[7:0]}, {1'b1, 8'h00}, "unmapped read");
  endtask : t_unmapped
  // ==========================================================================
  // Clock, run and watchdog
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    check_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_clamp;
    t_load;
    play(1'b0, 2, 0, 8);
    play(1'b0, 3, 3, 12);
    play(1'b1, 4, 2, 10);
    t_reload;
    t_midreset;
    t_unmapped;
    finish_test;
  end
  // The run needs fewer than two hundred cycles; this limit leaves ample margin.
  initial begin
    #400000;
    fail_count++;
    finish_test;
  end
endmodule : tb_top
`default_nettype wire

//--- test/wsp_sink_model.sv
// Model of the converter and the digital pins that the playback block drives.
`timescale 1ns/10ps
`default_nettype none
module wsp_sink_model (
  input wire logic [wsp_pkg::SAMPLE_W-1:0] dac_data,
  input wire logic dac_oe,
  input wire logic [wsp_pkg::DIG_W-1:0] dig_out,
  input wire logic dig_oe,
  output logic [wsp_pkg::SAMPLE_W-1:0] dac_level,
  output logic [wsp_pkg::DIG_W-1:0] pin_level
);
  // ==========================================================================
  // Pin levels
  // Undriven lines sit on pull-downs, so a stale sample can never pass for a live one.
  assign dac_level = dac_oe ? dac_data : '0;
  assign pin_level = dig_oe ? dig_out : '0;
endmodule : wsp_sink_model
`default_nettype wire

//--- verilog/wsp_mem_if.sv
// Interface between the playback engine and its sample memory.
`timescale 1ns/10ps
`default_nettype none
interface wsp_mem_if;
  logic we;
  logic [wsp_pkg::ADDR_W-1:0] wa;
  logic [wsp_pkg::SAMPLE_W-1:0] wd;
  logic [wsp_pkg::ADDR_W-1:0] ra;
  logic [wsp_pkg::SAMPLE_W-1:0] rd;
  modport ctrl (output we, output wa, output wd, output ra, input rd);
  modport mem (input we, input wa, input wd, input ra, output rd);
endinterface : wsp_mem_if
`default_nettype wire

//--- verilog/wsp_pkg.sv
// Package of constants and types shared by the waveform sample playback block.
package wsp_pkg;
  // ==========================================================================
  // Memory and sample geometry
  localparam int MEM_DEPTH = 2048;
  localparam int ADDR_W = 11;
  localparam int CNT_W = 12;
  localparam int SAMPLE_W = 8;
  localparam int HOLD_W = 8;
  localparam int DIG_W = 4;
  localparam logic [CNT_W-1:0] COUNT_MIN = 12'h001;
  localparam logic [CNT_W-1:0] COUNT_MAX = 12'h800;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 8'h01;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam logic [7:0] OFS_WADDR = 8'h0C;
  localparam logic [7:0] OFS_WDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ==========================================================================
  // Field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_BYTE_BIT = 1;
  localparam int STAT_PLAY_BIT = 0;
  localparam int STAT_PTR_LSB = 16;
  localparam logic [CNT_W-1:0] COUNT_RST = 12'h800;
  localparam logic [HOLD_W-1:0] HOLD_RST = 8'h00;

  // ==========================================================================
  // Whole state of the playback engine
  typedef struct packed {
    logic out_en;
    logic byte_mode;
    logic [CNT_W-1:0] count;
    logic [HOLD_W-1:0] hold;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] ptr;
    logic [HOLD_W-1:0] hold_cnt;
    logic primed;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [SAMPLE_W-1:0] dac;
    logic dac_oe;
    logic [DIG_W-1:0] dig;
    logic dig_oe;
    logic mem_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [SAMPLE_W-1:0] mem_wd;
  } wsp_state_s;
endpackage : wsp_pkg

//--- verilog/wsp_playback.sv
// Waveform sample playback engine with its register slave.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - The engine runs on the APB clock pclk and reads a memory of 2048 sample entries.
// - The sample count is 1 to 2048 and playback loops from the last sample to the first.
// - A hold count of 0 to 255 sets how many cycles each sample stays before the next.
// - The byte mode flag sends samples to the digital pins when 1 and to the converter when 0.
// - Loading memory never starts output; output is driven only while the enable is set.
// - Entries at or beyond the sample count are never played.
// - A hold count of 0 updates every cycle and a hold count of n updates every n cycles.
// - In byte mode the low four sample bits drive digital outputs 0 to 3 in order.
module wsp_playback (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [wsp_pkg::SAMPLE_W-1:0] dac_data,
  output logic dac_oe,
  output logic [wsp_pkg::DIG_W-1:0] dig_out,
  output logic dig_oe
);
  // ==========================================================================
  // Helpers
  function automatic logic [wsp_pkg::CNT_W-1:0] clamp_count(input logic [31:0] v);
    if (v < 32'(wsp_pkg::COUNT_MIN)) begin
      clamp_count = wsp_pkg::COUNT_MIN;
    end else if (v > 32'(wsp_pkg::COUNT_MAX)) begin
      clamp_count = wsp_pkg::COUNT_MAX;
    end else begin
      clamp_count = v[wsp_pkg::CNT_W-1:0];
    end
  endfunction : clamp_count

  function automatic logic [wsp_pkg::HOLD_W-1:0] hold_period(input logic [wsp_pkg::HOLD_W-1:0] h);
    hold_period = (h < wsp_pkg::HOLD_ONE) ? wsp_pkg::HOLD_ONE : h;
  endfunction : hold_period

  function automatic logic [wsp_pkg::ADDR_W-1:0] next_ptr(
    input logic [wsp_pkg::ADDR_W-1:0] p,
    input logic [wsp_pkg::CNT_W-1:0] c
  );
    logic [wsp_pkg::CNT_W-1:0] n;
    n = {1'b0, p} + 12'h001;
    next_ptr = (n >= c) ? '0 : n[wsp_pkg::ADDR_W-1:0];
  endfunction : next_ptr

  // ==========================================================================
  // State and memory
  wsp_pkg::wsp_state_s st_reg;
  wsp_pkg::wsp_state_s st_next;
  wsp_mem_if mif ();

  wsp_sample_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .port(mif.mem)
  );

  assign mif.we = st_reg.mem_we;
  assign mif.wa = st_reg.mem_wa;
  assign mif.wd = st_reg.mem_wd;
  assign mif.ra = st_reg.ptr;

  logic wr_acc;
  logic setup;
  logic restart;
  logic advance;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && st_reg.pready && pwrite;
  // Any write that changes what is played restarts the sequence, so a stale pointer
  // beyond a shortened count can never be used.
  assign restart = wr_acc && ((paddr == wsp_pkg::OFS_CTRL && pwdata[wsp_pkg::CTRL_EN_BIT]
                   && !st_reg.out_en) || paddr == wsp_pkg::OFS_WDATA
                   || paddr == wsp_pkg::OFS_COUNT || paddr == wsp_pkg::OFS_HOLD);
  assign advance = st_reg.out_en && !restart
                   && (st_reg.hold_cnt + 8'h01 >= hold_period(st_reg.hold));

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.mem_we = 1'b0;
    st_next.pready = setup;
    st_next.pslverr = 1'b0;
    if (setup) begin
      st_next.prdata = '0;
      if (paddr == wsp_pkg::OFS_CTRL) begin
        st_next.prdata[wsp_pkg::CTRL_EN_BIT] = st_reg.out_en;
        st_next.prdata[wsp_pkg::CTRL_BYTE_BIT] = st_reg.byte_mode;
      end else if (paddr == wsp_pkg::OFS_COUNT) begin
        st_next.prdata[wsp_pkg::CNT_W-1:0] = st_reg.count;
      end else if (paddr == wsp_pkg::OFS_HOLD) begin
        st_next.prdata[wsp_pkg::HOLD_W-1:0] = st_reg.hold;
      end else if (paddr == wsp_pkg::OFS_WADDR) begin
        st_next.prdata[wsp_pkg::ADDR_W-1:0] = st_reg.waddr;
      end else if (paddr == wsp_pkg::OFS_STATUS) begin
        st_next.prdata[wsp_pkg::STAT_PLAY_BIT] = st_reg.primed;
        st_next.prdata[wsp_pkg::STAT_PTR_LSB +: wsp_pkg::ADDR_W] = st_reg.ptr;
      end else if (paddr != wsp_pkg::OFS_WDATA) begin
        st_next.pslverr = 1'b1;
      end
    end
    if (wr_acc) begin
      if (paddr == wsp_pkg::OFS_CTRL) begin
        st_next.out_en = pwdata[wsp_pkg::CTRL_EN_BIT];
        st_next.byte_mode = pwdata[wsp_pkg::CTRL_BYTE_BIT];
      end else if (paddr == wsp_pkg::OFS_COUNT) begin
        st_next.count = clamp_count(pwdata);
      end else if (paddr == wsp_pkg::OFS_HOLD) begin
        st_next.hold = pwdata[wsp_pkg::HOLD_W-1:0];
      end else if (paddr == wsp_pkg::OFS_WADDR) begin
        st_next.waddr = pwdata[wsp_pkg::ADDR_W-1:0];
      end else if (paddr == wsp_pkg::OFS_WDATA) begin
        st_next.mem_we = 1'b1;
        st_next.mem_wa = st_reg.waddr;
        st_next.mem_wd = pwdata[wsp_pkg::SAMPLE_W-1:0];
        st_next.waddr = st_reg.waddr + 11'h001;
      end
    end
    if (restart) begin
      st_next.ptr = '0;
      st_next.hold_cnt = '0;
      st_next.primed = 1'b0;
    end else if (st_reg.out_en) begin
      st_next.primed = 1'b1;
      if (advance) begin
        st_next.hold_cnt = '0;
        st_next.ptr = next_ptr(st_reg.ptr, st_reg.count);
      end else begin
        st_next.hold_cnt = st_reg.hold_cnt + 8'h01;
      end
    end
    // The memory read is one cycle late, so outputs wait one cycle after each restart.
    if (st_reg.out_en && st_reg.primed && !restart) begin
      st_next.dac_oe = !st_reg.byte_mode;
      st_next.dig_oe = st_reg.byte_mode;
      if (st_reg.byte_mode) begin
        st_next.dig = mif.rd[wsp_pkg::DIG_W-1:0];
      end else begin
        st_next.dac = mif.rd;
      end
    end else begin
      st_next.dac_oe = 1'b0;
      st_next.dig_oe = 1'b0;
      st_next.dac = '0;
      st_next.dig = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.count <= wsp_pkg::COUNT_RST;
      st_reg.hold <= wsp_pkg::HOLD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign dac_data = st_reg.dac;
  assign dac_oe = st_reg.dac_oe;
  assign dig_out = st_reg.dig;
  assign dig_oe = st_reg.dig_oe;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_restart;
    restart;
  endsequence
  sequence s_fresh;
    st_reg.ptr == '0 && st_reg.hold_cnt == '0 && !st_reg.primed;
  endsequence
  sequence s_play_byte;
    st_reg.out_en && st_reg.primed && st_reg.byte_mode && !restart;
  endsequence

  count_range_a: assert property (st_reg.count >= wsp_pkg::COUNT_MIN
    && st_reg.count <= wsp_pkg::COUNT_MAX) else $error("count out of range");
  ptr_bound_a: assert property ({1'b0, st_reg.ptr} < st_reg.count)
    else $error("pointer reached an unplayed entry");
  loop_wrap_a: assert property (advance && {1'b0, st_reg.ptr} == st_reg.count - 12'h001
    |=> st_reg.ptr == '0) else $error("no wrap to first sample");
  hold_bound_a: assert property (st_reg.hold_cnt < hold_period(st_reg.hold))
    else $error("hold counter overran");
  // Judged on the pointer itself, so a broken advance term cannot pass unseen.
  update_rate_a: assert property (st_reg.out_en && !restart
    && st_reg.hold_cnt == hold_period(st_reg.hold) - 8'h01 |=> st_reg.hold_cnt == '0
    && (st_reg.ptr != $past(st_reg.ptr) || st_reg.count == wsp_pkg::COUNT_MIN))
    else $error("sample not advanced at end of hold");
  quiet_off_a: assert property (!st_reg.out_en |=> !dac_oe && !dig_oe)
    else $error("output driven while disabled");
  one_dest_a: assert property ((dig_oe |-> !dac_oe && $past(st_reg.byte_mode))
    and (dac_oe |-> !$past(st_reg.byte_mode)))
    else $error("sample sent to wrong destination");
  dig_bits_a: assert property (s_play_byte |=> dig_out == $past(mif.rd[wsp_pkg::DIG_W-1:0]))
    else $error("digital pins differ from sample bits");
  restart_fresh_a: assert property (s_restart |=> s_fresh ##1 !dac_oe && !dig_oe)
    else $error("restart did not begin at first sample");
endmodule : wsp_playback
`default_nettype wire

//--- verilog/wsp_sample_mem.sv
// Sample memory with one write port and one registered read port.
`timescale 1ns/10ps
`default_nettype none
module wsp_sample_mem (
  input wire logic pclk,
  input wire logic presetn,
  wsp_mem_if.mem port
);
  // ==========================================================================
  // Storage
  logic [wsp_pkg::SAMPLE_W-1:0] mem [wsp_pkg::MEM_DEPTH];

  always_ff @(posedge pclk) begin
    if (port.we) begin
      mem[port.wa] <= port.wd;
    end
  end

  // The read port is registered so that the array can map onto block RAM.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port.rd <= '0;
    end else begin
      port.rd <= mem[port.ra];
    end
  end
endmodule : wsp_sample_mem
`default_nettype wire
